/* File: lbx_partner.sv */
// Behavioural model of the expander UART devices on the local bus
`timescale 1ns/100ps
module lbx_partner (
   input  wire logic [3:0] cs_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [6:0] addr,
   input  wire logic [7:0] data_o,
   input  wire logic       oe_n,
   output logic      [7:0] data_i
);
   logic [7:0] mem [128];
   logic [7:0] last = 8'h00;
   logic [1:0] dev;

   // Storage keyed by the select line, so a wrong select returns wrong data
   assign dev = !cs_n[0] ? 2'd0 : !cs_n[1] ? 2'd1 : !cs_n[2] ? 2'd2 : 2'd3;

   always @(posedge wr_n) begin
      if (cs_n != 4'hf && !oe_n) mem[{dev, addr[4:0]}] <= data_o;
   end
   always @(posedge rd_n) begin
      last <= mem[{dev, addr[4:0]}];
   end
   // A released bus shows the inverse of the last byte, so a late sample fails
   assign data_i = (!rd_n && cs_n != 4'hf) ? mem[{dev, addr[4:0]}] : ~last;
endmodule

/* File: lbx_pkg.sv */
// Constants and types for the local bus expander configuration block
//----------------------------------------------------------------------
// Function
//----------------------------------------------------------------------
// Function
// - Timing one holds read/write chip-select and strobe de-assertion times.
// - Timing two low bytes hold write-data drive start 0 and end F.
// - Timing two bits 15:8 hold read sample start 4 and end 0.
// - Window-size field resets to 4; 4 gives 32 bytes, 6 gives 128.
// - Lower chip-select decode resets to 1; 5 decodes from address bit 5.
// - One timing-two bit, reset 0, enables the buffered local-bus clock.
// - One expander: address 4:3 channel, 2:0 register, first select always.
// - Four expanders: address 6:5 picks expander and its chip-select line.
// - Config register bits 1:0 and 31 report the three mode straps.
// - Misc register bits 26, 27, 28 report read-only mode status; 25 reserved.
// - Misc register bits 29, 30, 31 are writable clock-run and filter controls.
// - In backward-compatible mode those status and control fields read zero.
// - Straps 000 and 100 both report identical function identifiers.
// - Function one registers stay put; function zero follows window layout.
// - Four channels share clock and depth strap; common config loaded at reset.
package lbx_pkg;
   // Register byte addresses
   localparam logic [7:0]  OFS_LCC   = 8'h00;
   localparam logic [7:0]  OFS_MIC   = 8'h04;
   localparam logic [7:0]  OFS_LT1   = 8'h08;
   localparam logic [7:0]  OFS_LT2   = 8'h0c;
   // Reset values and the misc write mask
   localparam logic [31:0] LT1_RST   = 32'h2130_2030;
   localparam logic [31:0] LT2_RST   = 32'h00c0_04f0;
   localparam logic [31:0] MIC_WMASK = 32'he000_0000;
   // Field positions
   localparam int          LCC_S2    = 31;
   localparam int          MIC_UNQ   = 26;
   localparam int          MIC_MPCI  = 27;
   localparam int          MIC_ENH   = 28;
   localparam int          LT2_WSZ   = 20;
   localparam int          LT2_LCS   = 23;
   localparam int          LT2_CKEN  = 30;
   // Function identifiers, arbitrary values
   localparam logic [15:0] FUNC0_ID  = 16'h1234;
   localparam logic [15:0] FUNC1_ID  = 16'h1235;

   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } lb_req_t;

   typedef struct packed {
      logic [3:0] cs_as;
      logic [3:0] cs_de;
      logic [3:0] st_as;
      logic [3:0] st_de;
   } lb_tim_t;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_RUN,
      SEQ_DONE
   } seq_state_t;
endpackage

/* File: lbx_properties.sv */
// Port-level checker for the local bus expander block
`timescale 1ns/100ps
module lbx_properties (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        STRAP_BIT_ZERO,
   input  wire logic        STRAP_BIT_ONE,
   input  wire logic        STRAP_BIT_TWO,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic [31:0] REG_RDATA,
   input  wire logic        REQ_DONE,
   input  wire logic        LOCAL_CLK,
   input  wire logic [3:0]  LOCAL_CHIP_SELECT_N,
   input  wire logic        LOCAL_RD_N,
   input  wire logic        LOCAL_WR_N,
   input  wire logic        LOCAL_DATA_OE_N,
   input  wire logic        UART_CFG_LOAD,
   input  wire logic [15:0] FUNC0_IDENT,
   input  wire logic [15:0] FUNC1_IDENT
);
   //-------------------------------------------------------------
   // Helper state
   //-------------------------------------------------------------
   logic first_q;
   logic enh_q;
   logic cken_q;

   // The enhanced strap is caught once, like the design, so mid-run noise on that pin is ignored
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         first_q <= 1'b1;
         enh_q   <= 1'b0;
      end else if (first_q) begin
         first_q <= 1'b0;
         enh_q   <= STRAP_BIT_TWO;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         cken_q <= 1'b0;
      end else if (REG_WR && REG_ADDR == lbx_pkg::OFS_LT2) begin
         cken_q <= REG_WDATA[30];
      end
   end

   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   sequence s_lcc_rd;
      REG_RD && REG_ADDR == lbx_pkg::OFS_LCC;
   endsequence
   sequence s_mic_rd;
      REG_RD && REG_ADDR == lbx_pkg::OFS_MIC && !enh_q;
   endsequence
   sequence s_clk_off;
      (!cken_q) [*3];
   endsequence
   sequence s_ident_ok;
      FUNC0_IDENT == lbx_pkg::FUNC0_ID && FUNC1_IDENT == lbx_pkg::FUNC1_ID;
   endsequence
   sequence s_strap_seen;
      {REG_RDATA[31], REG_RDATA[1:0]} == {STRAP_BIT_TWO, STRAP_BIT_ONE, STRAP_BIT_ZERO};
   endsequence

   cs_onehot_a: assert property ($onehot0(~LOCAL_CHIP_SELECT_N))
      else $error("more than one chip select active");
   strobe_excl_a: assert property (LOCAL_RD_N || LOCAL_WR_N)
      else $error("read and write strobes together");
   drive_write_a: assert property (!LOCAL_DATA_OE_N |-> LOCAL_RD_N)
      else $error("data driven during read strobe");
   done_pulse_a: assert property (REQ_DONE |=> !REQ_DONE)
      else $error("done longer than one cycle");
   clk_gated_a: assert property (s_clk_off |-> !LOCAL_CLK)
      else $error("local clock runs while disabled");
   ident_fixed_a: assert property (!$past(SYS_RST) |-> s_ident_ok)
      else $error("function identifier wrong");
   cfg_load_a: assert property ($fell(SYS_RST) |-> ##[0:2] UART_CFG_LOAD)
      else $error("channel config not loaded after reset");
   load_pulse_a: assert property (UART_CFG_LOAD |=> !UART_CFG_LOAD)
      else $error("config load longer than one cycle");
   strap_report_a: assert property (s_lcc_rd |=> s_strap_seen)
      else $error("strap levels misreported");
   compat_zero_a: assert property (s_mic_rd |=> REG_RDATA[31:25] == 7'h00)
      else $error("mode fields nonzero in compatible mode");
endmodule

bind lbx_top lbx_properties chk (.CLK(CLK), .SYS_RST(SYS_RST),
   .STRAP_BIT_ZERO(STRAP_BIT_ZERO), .STRAP_BIT_ONE(STRAP_BIT_ONE),
   .STRAP_BIT_TWO(STRAP_BIT_TWO), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .REQ_DONE(REQ_DONE), .LOCAL_CLK(LOCAL_CLK), .LOCAL_CHIP_SELECT_N(LOCAL_CHIP_SELECT_N),
   .LOCAL_RD_N(LOCAL_RD_N), .LOCAL_WR_N(LOCAL_WR_N), .LOCAL_DATA_OE_N(LOCAL_DATA_OE_N),
   .UART_CFG_LOAD(UART_CFG_LOAD), .FUNC0_IDENT(FUNC0_IDENT), .FUNC1_IDENT(FUNC1_IDENT));

/* File: lbx_tb_top.sv */
// Self-checking bench for the local bus expander block
`timescale 1ns/100ps
module lbx_tb_top;
   logic CLK, SYS_RST, STRAP_BIT_ZERO, STRAP_BIT_ONE, STRAP_BIT_TWO, FIFO_DEPTH_STRAP;
   logic UNIQUE_WIN_LOADED, MINIPCI_MODE, REG_WR, REG_RD, REQ_VALID, REQ_READY;
   logic REQ_DONE, LOCAL_CLK, LOCAL_RD_N, LOCAL_WR_N, LOCAL_DATA_OE_N, LOCAL_TRANS_EN;
   logic F0_REGS_UNIQUE, UART_CFG_LOAD, UART_FIFO_DEEP, ck_hi;
   logic [7:0]       REG_ADDR, RD_DATA, LOCAL_DATA_O, LOCAL_DATA_I, d;
   logic [31:0]      REG_WDATA, REG_RDATA, rnd, v;
   logic [3:0]       LOCAL_CHIP_SELECT_N;
   logic [6:0]       LOCAL_ADDR, a;
   logic [15:0]      FUNC0_IDENT, FUNC1_IDENT;
   logic [7:0]       shadow [128];
   lbx_pkg::lb_req_t REQ;
   int               mismatches, n_compared, cycles;

   lbx_top uut (.*);
   lbx_partner far (.cs_n(LOCAL_CHIP_SELECT_N), .rd_n(LOCAL_RD_N), .wr_n(LOCAL_WR_N),
      .addr(LOCAL_ADDR), .data_o(LOCAL_DATA_O), .oe_n(LOCAL_DATA_OE_N), .data_i(LOCAL_DATA_I));

   //-------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Window is 2^(size+1) bytes; the lower decode sits at address bit 5
   function automatic logic [3:0] exp_cs(input logic [6:0] ad, input logic [2:0] sz);
      if (32'(ad) >= (32'd1 << (sz + 3'd1))) return 4'hf;
      return ~(4'd1 << ad[6:5]);
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic stop_test;
      $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] ad, input logic [31:0] wd);
      REG_ADDR = ad;
      REG_WDATA = wd;
      REG_WR = 1'b1;
      @(posedge CLK);
      #2 REG_WR = 1'b0;
      @(posedge CLK);
      #2;
   endtask

   task automatic rd_reg(input logic [7:0] ad);
      REG_ADDR = ad;
      REG_RD = 1'b1;
      @(posedge CLK);
      #2 REG_RD = 1'b0;
      v = REG_RDATA;
      @(posedge CLK);
      #2;
   endtask

   task automatic bus(input logic wr, input logic [6:0] ad, input logic [7:0] wd,
                      input logic [2:0] sz);
      logic [3:0] cs_seen;
      logic       te_seen;
      int         n;
      cs_seen = 4'hf;
      te_seen = 1'b0;
      n = 0;
      REQ = {wr, ad, wd};
      REQ_VALID = 1'b1;
      do begin
         @(posedge CLK);
         #2 cs_seen = cs_seen & LOCAL_CHIP_SELECT_N;
         te_seen = te_seen | LOCAL_TRANS_EN;
         ck_hi = ck_hi | LOCAL_CLK;
         n++;
      end while (REQ_DONE !== 1'b1 && n < 200);
      REQ_VALID = 1'b0;
      check(n < 200, 1);
      check(cs_seen, exp_cs(ad, sz));
      // Read end of zero keeps the transceiver open on every in-window read
      check(te_seen, !wr && (exp_cs(ad, sz) != 4'hf));
      if (cs_seen != 4'hf) begin
         check(LOCAL_ADDR, ad);
         if (wr) shadow[ad] = wd;
         else check(RD_DATA, shadow[ad]);
      end
      @(posedge CLK);
      #2 check(REQ_READY, 1);
   endtask

   task automatic mode_checks(input logic [2:0] m);
      SYS_RST = 1'b1;
      {STRAP_BIT_TWO, STRAP_BIT_ONE, STRAP_BIT_ZERO} = m;
      {FIFO_DEPTH_STRAP, UNIQUE_WIN_LOADED, MINIPCI_MODE} = rnd[2:0];
      repeat (4) @(posedge CLK);
      #2 SYS_RST = 1'b0;
      repeat (2) @(posedge CLK);
      #2 check(UART_FIFO_DEEP, FIFO_DEPTH_STRAP);
      check(FUNC0_IDENT, lbx_pkg::FUNC0_ID);
      check(FUNC1_IDENT, lbx_pkg::FUNC1_ID);
      rd_reg(lbx_pkg::OFS_LCC);
      check({v[31], v[1:0]}, m);
      wr_reg(lbx_pkg::OFS_MIC, 32'hffff_ffff);
      rd_reg(lbx_pkg::OFS_MIC);
      if (m[2]) begin
         check(v[31:26], {4'hf, MINIPCI_MODE, UNIQUE_WIN_LOADED});
         check(F0_REGS_UNIQUE, UNIQUE_WIN_LOADED);
      end else begin
         check(v[31:25], 0);
      end
      wr_reg(lbx_pkg::OFS_MIC, 32'h0000_0000);
      rd_reg(lbx_pkg::OFS_MIC);
      check(v[31:29], 0);
   endtask

   //-------------------------------------------------------------
   // Clock, timeout and main sequence
   //-------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      {REG_WR, REG_RD, REQ_VALID, REG_ADDR, REG_WDATA, REQ} = '0;
      {mismatches, n_compared, cycles} = '0;
      ck_hi = 1'b0;
      rnd = 32'hc8ab225b;
      mode_checks(3'b000);
      rd_reg(lbx_pkg::OFS_LT1);
      check(v & 32'hf0f0_f0f0, 32'h2030_2030);
      rd_reg(lbx_pkg::OFS_LT2);
      check(v & 32'h47f0_ffff, 32'h00c0_04f0);
      rd_reg(8'h10);
      check(v, 0);
      rnd = lfsr(rnd);
      wr_reg(lbx_pkg::OFS_LT1, rnd);
      rd_reg(lbx_pkg::OFS_LT1);
      check(v, rnd);
      wr_reg(lbx_pkg::OFS_LT1, (lbx_pkg::LT1_RST & ~32'h00f0_f0f0) | 32'h0040_4040);
      for (int sz = 4; sz <= 6; sz += 2) begin
         wr_reg(lbx_pkg::OFS_LT2, 32'h4280_04f0 | (32'(sz) << 20));
         for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            a = (i == 0) ? 7'h60 : rnd[6:0] & ((sz == 4) ? 7'h1f : 7'h7f);
            d = rnd[15:8];
            bus(1'b1, a, d, 3'(sz));
            bus(1'b0, a, 8'h00, 3'(sz));
         end
      end
      check(ck_hi, 1);
      mode_checks(3'b100);
      stop_test();
   end
endmodule

/* File: lbx_top.sv */
// Local bus expander configuration: local registers and 8-bit bus sequencer
`timescale 1ns/100ps
module lbx_top (
   input  wire logic                CLK,
   input  wire logic                SYS_RST,
   input  wire logic                STRAP_BIT_ZERO,
   input  wire logic                STRAP_BIT_ONE,
   input  wire logic                STRAP_BIT_TWO,
   input  wire logic                FIFO_DEPTH_STRAP,
   input  wire logic                UNIQUE_WIN_LOADED,
   input  wire logic                MINIPCI_MODE,
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   input  wire logic [7:0]          REG_ADDR,
   input  wire logic [31:0]         REG_WDATA,
   output logic      [31:0]         REG_RDATA,
   input  wire logic                REQ_VALID,
   input  wire lbx_pkg::lb_req_t    REQ,
   output logic                     REQ_READY,
   output logic                     REQ_DONE,
   output logic      [7:0]          RD_DATA,
   output logic                     LOCAL_CLK,
   output logic      [3:0]          LOCAL_CHIP_SELECT_N,
   output logic                     LOCAL_RD_N,
   output logic                     LOCAL_WR_N,
   output logic      [6:0]          LOCAL_ADDR,
   output logic      [7:0]          LOCAL_DATA_O,
   output logic                     LOCAL_DATA_OE_N,
   input  wire logic [7:0]          LOCAL_DATA_I,
   output logic                     LOCAL_TRANS_EN,
   output logic                     F0_REGS_UNIQUE,
   output logic                     UART_CFG_LOAD,
   output logic                     UART_FIFO_DEEP,
   output logic      [15:0]         FUNC0_IDENT,
   output logic      [15:0]         FUNC1_IDENT
);

   //----------------------------------------------------------------------
   // Strap capture
   //----------------------------------------------------------------------
   // Straps are caught on the first edge after release, never by the reset itself
   logic [2:0]  strap_q;
   logic        strap_done_q;
   logic        fifo_deep_q;
   logic        cfg_sent_q;
   logic        enh;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         strap_q      <= 3'h0;
         strap_done_q <= 1'b0;
         fifo_deep_q  <= 1'b0;
      end else if (!strap_done_q) begin
         strap_q      <= {STRAP_BIT_TWO, STRAP_BIT_ONE, STRAP_BIT_ZERO};
         fifo_deep_q  <= FIFO_DEPTH_STRAP;
         strap_done_q <= 1'b1;
      end
   end

   // Straps 000 and 100 differ only in the enhanced bit
   assign enh = strap_q[2];

   // One common configuration pulse for all four channels
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         UART_CFG_LOAD  <= 1'b0;
         cfg_sent_q     <= 1'b0;
         UART_FIFO_DEEP <= 1'b0;
         FUNC0_IDENT    <= 16'h0000;
         FUNC1_IDENT    <= 16'h0000;
         F0_REGS_UNIQUE <= 1'b0;
      end else begin
         // Pulse one cycle after capture, so the depth strap already stands beside it
         UART_CFG_LOAD  <= strap_done_q & !cfg_sent_q;
         cfg_sent_q     <= strap_done_q;
         UART_FIFO_DEEP <= fifo_deep_q;
         FUNC0_IDENT    <= lbx_pkg::FUNC0_ID;
         FUNC1_IDENT    <= lbx_pkg::FUNC1_ID;
         F0_REGS_UNIQUE <= enh & UNIQUE_WIN_LOADED;
      end
   end

   //----------------------------------------------------------------------
   // Local registers
   //----------------------------------------------------------------------
   logic [31:0] lt1_q;
   logic [31:0] lt2_q;
   logic [31:0] mic_ctl_q;
   logic [31:0] mic_rd;
   logic [31:0] lcc_rd;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lt1_q     <= lbx_pkg::LT1_RST;
         lt2_q     <= lbx_pkg::LT2_RST;
         mic_ctl_q <= 32'h0000_0000;
      end else if (REG_WR) begin
         case (REG_ADDR)
            lbx_pkg::OFS_LT1: begin
               lt1_q <= REG_WDATA;
            end
            lbx_pkg::OFS_LT2: begin
               lt2_q <= REG_WDATA;
            end
            lbx_pkg::OFS_MIC: begin
               // Backward-compatible parts ignore the write entirely
               if (enh) begin
                  mic_ctl_q <= REG_WDATA & lbx_pkg::MIC_WMASK;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      lcc_rd = 32'h0000_0000;
      lcc_rd[1:0] = strap_q[1:0];
      lcc_rd[lbx_pkg::LCC_S2] = strap_q[2];
      mic_rd = 32'h0000_0000;
      if (enh) begin
         mic_rd = mic_ctl_q;
         mic_rd[lbx_pkg::MIC_UNQ]  = UNIQUE_WIN_LOADED;
         mic_rd[lbx_pkg::MIC_MPCI] = MINIPCI_MODE;
         mic_rd[lbx_pkg::MIC_ENH]  = 1'b1;
      end
   end

   // Read data is registered; unmapped addresses return zero
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RDATA <= 32'h0000_0000;
      end else if (REG_RD) begin
         case (REG_ADDR)
            lbx_pkg::OFS_LCC: REG_RDATA <= lcc_rd;
            lbx_pkg::OFS_MIC: REG_RDATA <= mic_rd;
            lbx_pkg::OFS_LT1: REG_RDATA <= lt1_q;
            lbx_pkg::OFS_LT2: REG_RDATA <= lt2_q;
            default:          REG_RDATA <= 32'h0000_0000;
         endcase
      end
   end

   //----------------------------------------------------------------------
   // Local bus clock
   //----------------------------------------------------------------------
   // Local bus runs at half the core rate; tick marks each local-bus cycle
   logic phase_q;
   logic tick;

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         phase_q   <= 1'b0;
         LOCAL_CLK <= 1'b0;
      end else begin
         phase_q   <= !phase_q;
         LOCAL_CLK <= lt2_q[lbx_pkg::LT2_CKEN] & !phase_q;
      end
   end

   assign tick = phase_q;

   //----------------------------------------------------------------------
   // Transaction sequencer
   //----------------------------------------------------------------------
   lbx_pkg::seq_state_t state_q;
   lbx_pkg::lb_req_t    req_q;
   logic [3:0]          cnt_q;
   lbx_pkg::lb_tim_t    tim;
   logic [3:0]          end_cnt;
   logic [3:0]          wd_as;
   logic [3:0]          wd_de;
   logic [3:0]          rd_as;
   logic [3:0]          rd_de;
   logic [7:0]          win_mask;
   logic [3:0]          lcs;
   logic [1:0]          cs_idx;
   logic                in_win;

   // Reads and writes take their own field set from timing one
   always_comb begin
      if (req_q.wr) begin
         tim = '{cs_as: lt1_q[11:8],  cs_de: lt1_q[15:12],
                 st_as: lt1_q[27:24], st_de: lt1_q[31:28]};
      end else begin
         tim = '{cs_as: lt1_q[3:0],   cs_de: lt1_q[7:4],
                 st_as: lt1_q[19:16], st_de: lt1_q[23:20]};
      end
      end_cnt = (tim.cs_de > tim.st_de) ? tim.cs_de : tim.st_de;
      if (end_cnt == 4'h0) begin
         end_cnt = 4'h1;
      end
   end

   assign wd_as = lt2_q[3:0];
   assign wd_de = lt2_q[7:4];
   assign rd_as = lt2_q[11:8];
   assign rd_de = lt2_q[15:12];
   assign lcs   = lt2_q[lbx_pkg::LT2_LCS +: 4];

   // Window is 2^(size+1) bytes: 4 gives 32, 6 gives 128
   // Size 7 wraps the shift to zero and leaves only address 0 inside the window
   assign win_mask = 8'(8'hff << (lt2_q[lbx_pkg::LT2_WSZ +: 3] + 3'h1));
   assign in_win   = (({1'b0, REQ.addr}) & win_mask) == 8'h00;
   // Chip-select index from the lower decode bit upward; with 5 this is addr[6:5]
   assign cs_idx   = 2'(req_q.addr >> lcs);

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_q <= lbx_pkg::SEQ_IDLE;
         req_q   <= '0;
         cnt_q   <= 4'h0;
      end else begin
         case (state_q)
            lbx_pkg::SEQ_IDLE: begin
               // Requests outside the window complete without bus activity
               if (REQ_VALID && tick) begin
                  req_q   <= REQ;
                  cnt_q   <= 4'h0;
                  state_q <= in_win ? lbx_pkg::SEQ_RUN : lbx_pkg::SEQ_DONE;
               end
            end
            lbx_pkg::SEQ_RUN: begin
               if (tick) begin
                  if (cnt_q == end_cnt) begin
                     state_q <= lbx_pkg::SEQ_DONE;
                  end else begin
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            lbx_pkg::SEQ_DONE: begin
               state_q <= lbx_pkg::SEQ_IDLE;
            end
            default: begin
               state_q <= lbx_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // Pin drive follows the count, one core cycle behind it
   logic run;
   logic cs_on;
   logic st_on;
   assign run   = (state_q == lbx_pkg::SEQ_RUN) && (cnt_q < end_cnt);
   // A de-assertion at or below its assertion leaves the pin idle
   assign cs_on = run && (cnt_q >= tim.cs_as) && (cnt_q < tim.cs_de);
   assign st_on = run && (cnt_q >= tim.st_as) && (cnt_q < tim.st_de);

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         LOCAL_CHIP_SELECT_N <= 4'hf;
         LOCAL_RD_N          <= 1'b1;
         LOCAL_WR_N          <= 1'b1;
         LOCAL_ADDR          <= 7'h00;
         LOCAL_DATA_O        <= 8'h00;
         LOCAL_DATA_OE_N     <= 1'b1;
         LOCAL_TRANS_EN      <= 1'b0;
      end else begin
         LOCAL_CHIP_SELECT_N <= cs_on ? ~(4'h1 << cs_idx) : 4'hf;
         LOCAL_RD_N          <= !(st_on && !req_q.wr);
         LOCAL_WR_N          <= !(st_on && req_q.wr);
         LOCAL_ADDR          <= req_q.addr;
         LOCAL_DATA_O        <= req_q.data;
         // Write data is driven between its start and end counts
         LOCAL_DATA_OE_N     <= !(run && req_q.wr && (cnt_q >= wd_as)
                                  && (cnt_q < wd_de));
         // Read end of zero keeps the transceiver open to the end of the cycle
         LOCAL_TRANS_EN      <= run && !req_q.wr
                                && ((rd_de == 4'h0) || (cnt_q < rd_de));
      end
   end

   //----------------------------------------------------------------------
   // Read capture and handshake
   //----------------------------------------------------------------------
   // Sampled as count rd_as begins, while the strobe of the count before still
   // stands on the pins; waiting for the next tick would see a released bus.
   // A start of zero samples before any strobe reaches the pins.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         RD_DATA <= 8'h00;
      end else if ((state_q == lbx_pkg::SEQ_RUN) && !tick && !req_q.wr
                   && (cnt_q == rd_as)) begin
         RD_DATA <= LOCAL_DATA_I;
      end
   end

   // Ready tells the requester that the sequencer is idle and REQ_VALID is low
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REQ_DONE  <= 1'b0;
         REQ_READY <= 1'b0;
      end else begin
         REQ_DONE  <= (state_q == lbx_pkg::SEQ_DONE);
         REQ_READY <= (state_q == lbx_pkg::SEQ_IDLE) && !REQ_VALID;
      end
   end

endmodule
